// file: src/msc_defs.svh
// Offsets, field positions, reset and restart masks for the mode/supply and hardware option registers
// Included by the register bank, the host model and the testbench; definitions only
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH

`define MSC_ADDR_MODE_SUPPLY 7'h01
`define MSC_ADDR_HW_OPTION 7'h02

// Mode and supply control fields
`define MSC_MODE_HI 15
`define MSC_MODE_LO 14
`define MSC_OVR_HI 10
`define MSC_OVR_LO 9
`define MSC_HYS_BIT 7
`define MSC_PEAK_BIT 5
`define MSC_RT_HI 1
`define MSC_RT_LO 0
`define MSC_MS_WMASK 16'hC6A3
`define MSC_MS_POR 16'h0000
`define MSC_MS_KEEP 16'h00A3

// Hardware option control fields
`define MSC_TWAIT_BIT 12
`define MSC_SOV_BIT 11
`define MSC_SHD_BIT 10
`define MSC_RDEL_BIT 9
`define MSC_SRPIN_BIT 6
`define MSC_SWFO_BIT 5
`define MSC_WDOFF1_BIT 2
`define MSC_HW_WMASK 16'h1E64
`define MSC_HW_POR 16'h0000
`define MSC_HW_SOFT_KEEP 16'h0200
`define MSC_HW_RESTART_KEEP 16'h1240

// Timing
`define MSC_CLK_HZ 25000000
`define MSC_RDEL_LONG_MS 10
`define MSC_RDEL_SHORT_MS 2
`define MSC_RDEL_LONG_CYC ((`MSC_CLK_HZ / 1000) * `MSC_RDEL_LONG_MS)
`define MSC_RDEL_SHORT_CYC ((`MSC_CLK_HZ / 1000) * `MSC_RDEL_SHORT_MS)

`endif

// file: src/msc_pkg.sv
// Types shared by the mode/supply register bank, the host model and the testbench
// Assumes msc_defs.svh is on the include path
package msc_pkg;

  typedef enum logic [1:0] {
    MSC_MODE_NORMAL = 2'h0,
    MSC_MODE_SLEEP = 2'h1,
    MSC_MODE_STOP = 2'h2,
    MSC_MODE_SOFTRST = 2'h3
  } msc_mode_e;

  typedef enum logic [1:0] {
    MSC_OV_NONE = 2'h0,
    MSC_OV_INT = 2'h1,
    MSC_OV_RST = 2'h2,
    MSC_OV_FAILSAFE = 2'h3
  } msc_ovr_e;

  // Register access from the serial frame engine
  typedef struct packed {
    logic valid;
    logic write;
    logic [6:0] addr;
    logic [15:0] wdata;
  } msc_req_s;

  // Decoded control outputs to the analogue and state logic
  typedef struct packed {
    logic hys_highest;
    logic peak_high;
    logic [1:0] reset_thr;
    logic thermal_wait_ext;
    logic supply_ov_high;
    logic sample_hold_off;
    logic reset_delay_short;
    logic soft_reset_keep_pin;
    logic watchdog_stop_off;
  } msc_cfg_s;

endpackage

// file: src/msc_field_reg.sv
// One 16-bit control register with write mask, zero reserved bits and masked preset
// Assumes the owner decodes address and supplies restart keep masks
`timescale 1ns/1ps
module msc_field_reg #(
  parameter logic [15:0] WMASK = 16'h0000,
  parameter logic [15:0] POR = 16'h0000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host write
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  // Hardware preset: bits outside keep take POR value
  input wire logic preset,
  input wire logic [15:0] keep,
  // Hardware bit overrides
  input wire logic [15:0] hw_clr,
  input wire logic [15:0] hw_set,
  // Stored value
  output logic [15:0] value
);

  logic [15:0] value_r;
  logic [15:0] value_nxt;

  always_comb begin
    value_nxt = value_r;
    if (preset) begin
      value_nxt = (value_r & keep) | (POR & ~keep);
    end else if (wr_en) begin
      value_nxt = wr_data;
    end
    value_nxt = (value_nxt & ~hw_clr) | hw_set;
    value_nxt = value_nxt & WMASK;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      value_r <= 16'h0000;
    end else begin
      value_r <= value_nxt;
    end
  end

  assign value = value_r;

endmodule

// file: src/msc_regs.sv
// Mode/supply and hardware option control register bank
// Assumes the serial frame engine delivers decoded word accesses on clk_sys
// What this block does
// R1: Mode field codes normal, sleep, stop; code three requests soft reset.
// R2: Host request for sleep while in stop does not move the device to sleep.
// R3: On restart entry the mode field is forced to normal.
// R4: Reading the mode register returns last written value, not reached state.
// R5: Overvoltage reaction codes none, interrupt, reset event, fail-safe.
// R6: Hysteresis bit one uses highest rising threshold to release reset.
// R7: Peak threshold bit selects low or high regulator peak threshold.
// R8: Reset threshold field picks one of four thresholds, code zero highest.
// R9: Reserved bits always read zero.
// R10: Thermal wait bit extends release wait sixty-four times after sixteen events.
// R11: Supply overvoltage bit selects default or increased threshold.
// R12: Sample-and-hold disable bit one switches sample-and-hold off.
// R13: Reset delay bit picks 10 ms or 2 ms release delay.
// R14: Soft reset pin option zero pulls reset output low on soft reset.
// R15: Software fail bit drives fail output only when pin is fail output.
// R16: Clearing software fail bit leaves failure-driven fail output on.
// R17: Restart clears software fail bit; failures keep fail output on.
// R18: Stop watchdog off bit one requests watchdog off in stop mode.
// R19: Stop watchdog off bit one clears on stop to normal change.
// R20: Watchdog stays off in stop only with companion bit zero set too.
// R21: Host reads with command bit seven zero, leaving register unchanged.
// R22: Host writes zero into reserved positions.
// R23: Power-on loads zero; restart keeps only marked unchanged bits.
`timescale 1ns/1ps
`include "msc_defs.svh"
module msc_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register access
  input wire msc_pkg::msc_req_s req,
  output logic [15:0] rdata,
  output logic rvalid,
  // Device state
  input wire logic in_stop,
  input wire logic in_normal,
  input wire logic restart_entry,
  input wire logic soft_reset_done,
  input wire logic wd_stop_off_bit_zero,
  input wire logic fail_pin_is_fail_output,
  input wire logic failure_flag,
  input wire logic overvoltage_event,
  // Mode requests
  output msc_pkg::msc_mode_e mode_request,
  output logic mode_req_pulse,
  output logic soft_reset_req,
  output logic soft_reset_pull_reset,
  // Overvoltage reaction pulses
  output logic ov_int_event,
  output logic ov_reset_event,
  output logic ov_failsafe_event,
  // Configuration
  output msc_pkg::msc_cfg_s cfg,
  output logic [31:0] reset_delay_cycles,
  output logic fail_output
);

  logic wr_ms;
  logic wr_hw;
  logic [15:0] ms_val;
  logic [15:0] hw_val;
  logic [15:0] ms_wdata;
  logic [15:0] ms_clr;
  logic [15:0] hw_clr;
  logic [15:0] hw_keep;
  logic hw_preset;
  logic in_stop_r;
  logic stop_to_normal;
  logic [1:0] req_mode;
  logic [1:0] ovr;
  logic [15:0] rdata_r;
  logic rvalid_r;
  logic mode_req_r;
  logic softrst_r;
  logic ov_int_r;
  logic ov_rst_r;
  logic ov_fs_r;

  // Read access leaves registers alone; only write frames store
  assign wr_ms = req.valid && req.write && (req.addr == `MSC_ADDR_MODE_SUPPLY); // see R21
  assign wr_hw = req.valid && req.write && (req.addr == `MSC_ADDR_HW_OPTION);

  // Sleep request while in stop keeps the stop code stored
  assign req_mode = req.wdata[`MSC_MODE_HI:`MSC_MODE_LO];
  always_comb begin
    ms_wdata = req.wdata;
    if (in_stop && (req_mode == msc_pkg::MSC_MODE_SLEEP)) begin // see R2
      ms_wdata[`MSC_MODE_HI:`MSC_MODE_LO] = msc_pkg::MSC_MODE_STOP;
    end
  end

  // Restart forces mode to normal, other bits follow keep mask
  always_comb begin
    ms_clr = 16'h0000;
    if (restart_entry) begin
      ms_clr[`MSC_MODE_HI:`MSC_MODE_LO] = 2'h3; // see R3
    end
  end

  msc_field_reg #(
    .WMASK(`MSC_MS_WMASK),
    .POR(`MSC_MS_POR)
  ) u_mode_supply (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_ms),
    .wr_data(ms_wdata),
    .preset(restart_entry || soft_reset_done),
    .keep(restart_entry ? `MSC_MS_KEEP : 16'h0000), // see R23
    .hw_clr(ms_clr),
    .hw_set(16'h0000),
    .value(ms_val)
  );

  // Stop to normal detection for the watchdog off bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_stop_r <= 1'b0;
    end else begin
      in_stop_r <= in_stop;
    end
  end
  assign stop_to_normal = in_stop_r && in_normal;

  always_comb begin
    hw_clr = 16'h0000;
    hw_clr[`MSC_WDOFF1_BIT] = stop_to_normal; // see R19
    hw_clr[`MSC_SWFO_BIT] = restart_entry; // see R17
  end

  assign hw_preset = restart_entry || soft_reset_done;
  assign hw_keep = restart_entry ? `MSC_HW_RESTART_KEEP : `MSC_HW_SOFT_KEEP; // see R23

  msc_field_reg #(
    .WMASK(`MSC_HW_WMASK),
    .POR(`MSC_HW_POR)
  ) u_hw_option (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_hw && !restart_entry),
    .wr_data(req.wdata),
    .preset(hw_preset),
    .keep(hw_keep),
    .hw_clr(hw_clr),
    .hw_set(16'h0000),
    .value(hw_val)
  );

  // Read path: stored value, reserved bits masked to zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= req.valid;
      if (req.valid) begin
        unique case (req.addr)
          `MSC_ADDR_MODE_SUPPLY: rdata_r <= ms_val & `MSC_MS_WMASK; // see R4, see R9
          `MSC_ADDR_HW_OPTION: rdata_r <= hw_val & `MSC_HW_WMASK; // see R9
          default: rdata_r <= 16'h0000;
        endcase
      end
    end
  end
  assign rdata = rdata_r;
  assign rvalid = rvalid_r;

  // Mode request pulse on each mode write, soft reset request on a mode write of code three
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_req_r <= 1'b0;
      softrst_r <= 1'b0;
    end else begin
      mode_req_r <= wr_ms;
      softrst_r <= wr_ms && (ms_wdata[`MSC_MODE_HI:`MSC_MODE_LO] == msc_pkg::MSC_MODE_SOFTRST); // see R1
    end
  end
  assign mode_request = msc_pkg::msc_mode_e'(ms_val[`MSC_MODE_HI:`MSC_MODE_LO]); // see R1
  assign mode_req_pulse = mode_req_r;
  assign soft_reset_req = softrst_r;
  assign soft_reset_pull_reset = softrst_r && !hw_val[`MSC_SRPIN_BIT]; // see R14

  // Overvoltage reaction routing
  assign ovr = ms_val[`MSC_OVR_HI:`MSC_OVR_LO];
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ov_int_r <= 1'b0;
      ov_rst_r <= 1'b0;
      ov_fs_r <= 1'b0;
    end else begin
      ov_int_r <= overvoltage_event && (ovr == msc_pkg::MSC_OV_INT); // see R5
      ov_rst_r <= overvoltage_event && (ovr == msc_pkg::MSC_OV_RST); // see R5
      ov_fs_r <= overvoltage_event && (ovr == msc_pkg::MSC_OV_FAILSAFE); // see R5
    end
  end
  assign ov_int_event = ov_int_r;
  assign ov_reset_event = ov_rst_r;
  assign ov_failsafe_event = ov_fs_r;

  // Decoded configuration
  always_comb begin
    cfg.hys_highest = ms_val[`MSC_HYS_BIT]; // see R6
    cfg.peak_high = ms_val[`MSC_PEAK_BIT]; // see R7
    cfg.reset_thr = ms_val[`MSC_RT_HI:`MSC_RT_LO]; // see R8
    cfg.thermal_wait_ext = hw_val[`MSC_TWAIT_BIT]; // see R10
    cfg.supply_ov_high = hw_val[`MSC_SOV_BIT]; // see R11
    cfg.sample_hold_off = hw_val[`MSC_SHD_BIT]; // see R12
    cfg.reset_delay_short = hw_val[`MSC_RDEL_BIT]; // see R13
    cfg.soft_reset_keep_pin = hw_val[`MSC_SRPIN_BIT]; // see R14
    cfg.watchdog_stop_off = hw_val[`MSC_WDOFF1_BIT] && wd_stop_off_bit_zero; // see R18, see R20
  end

  assign reset_delay_cycles = hw_val[`MSC_RDEL_BIT] ? 32'(`MSC_RDEL_SHORT_CYC) : 32'(`MSC_RDEL_LONG_CYC); // see R13

  // Fail output: software request gated by pin config, failures always win
  assign fail_output = failure_flag || (hw_val[`MSC_SWFO_BIT] && fail_pin_is_fail_output); // see R15, see R16

  // Assertions
  a_restart_mode_normal: assert property (@(posedge clk_sys) disable iff (rst) // see R3
    restart_entry |=> (ms_val[15:14] == 2'h0))
    else $error("mode not normal after restart");

  a_stop_no_sleep: assert property (@(posedge clk_sys) disable iff (rst) // see R2
    (wr_ms && in_stop && !restart_entry && !soft_reset_done) |=> (ms_val[15:14] != 2'h1))
    else $error("stop moved to sleep by write");

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst) // see R9
    (rvalid && $past(req.addr) == `MSC_ADDR_MODE_SUPPLY) |-> ((rdata & ~`MSC_MS_WMASK) == 16'h0000))
    else $error("reserved bit read nonzero");

  a_hw_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst) // see R9
    (rvalid && $past(req.addr) == `MSC_ADDR_HW_OPTION) |-> ((rdata & ~`MSC_HW_WMASK) == 16'h0000))
    else $error("hardware reserved bit read nonzero");

  a_readback_written: assert property (@(posedge clk_sys) disable iff (rst) // see R4
    (wr_ms && !in_stop && !restart_entry && !soft_reset_done) ##1 (!wr_ms && !restart_entry && !soft_reset_done)
      ##1 (req.valid && !req.write && req.addr == `MSC_ADDR_MODE_SUPPLY)
      |=> (rdata == ($past(req.wdata, 3) & `MSC_MS_WMASK)))
    else $error("readback differs from write");

  a_wdoff_clear: assert property (@(posedge clk_sys) disable iff (rst) // see R19
    stop_to_normal |=> !hw_val[2])
    else $error("watchdog off bit not cleared");

  a_swfo_restart: assert property (@(posedge clk_sys) disable iff (rst) // see R17
    restart_entry |=> (!hw_val[5] && (fail_output == failure_flag)))
    else $error("software fail bit survived restart");

  a_fail_held: assert property (@(posedge clk_sys) disable iff (rst) // see R16
    failure_flag |-> fail_output)
    else $error("fail output dropped with failure");

  a_softrst_pin: assert property (@(posedge clk_sys) disable iff (rst) // see R14
    (wr_ms && req.wdata[15:14] == 2'h3 && !in_stop && !hw_val[6] && !wr_hw) |=> soft_reset_pull_reset)
    else $error("soft reset did not pull reset");

  a_ov_route: assert property (@(posedge clk_sys) disable iff (rst) // see R5
    (overvoltage_event && ms_val[10:9] == 2'h2) |=> (ov_reset_event && !ov_int_event && !ov_failsafe_event))
    else $error("overvoltage reaction misrouted");

  a_rdel_select: assert property (@(posedge clk_sys) disable iff (rst) // see R13
    hw_val[9] |-> (reset_delay_cycles == 32'h0000C350))
    else $error("short reset delay wrong");

  a_rdel_long: assert property (@(posedge clk_sys) disable iff (rst) // see R13
    !hw_val[9] |-> (reset_delay_cycles == 32'h0003D090))
    else $error("long reset delay wrong");

  a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (rst) // see R9
    (rvalid && $past(req.addr) != `MSC_ADDR_MODE_SUPPLY && $past(req.addr) != `MSC_ADDR_HW_OPTION)
      |-> (rdata == 16'h0000))
    else $error("unmapped read nonzero");

  a_mode_pulse: assert property (@(posedge clk_sys) disable iff (rst) // see R1
    wr_ms |=> mode_req_pulse)
    else $error("mode write gave no request pulse");

  a_softrst_req: assert property (@(posedge clk_sys) disable iff (rst) // see R1
    (wr_ms && req.wdata[15:14] == 2'h3) |=> soft_reset_req)
    else $error("soft reset code gave no request");

  a_no_softrst: assert property (@(posedge clk_sys) disable iff (rst) // see R1
    !wr_ms |=> !soft_reset_req)
    else $error("soft reset request without write");

  a_mode_stored: assert property (@(posedge clk_sys) disable iff (rst) // see R1
    (wr_ms && !in_stop && !restart_entry && !soft_reset_done)
      |=> ((ms_val & 16'hC000) == ($past(req.wdata) & 16'hC000)))
    else $error("mode code not stored");

  a_softrst_keep_pin: assert property (@(posedge clk_sys) disable iff (rst) // see R14
    hw_val[6] |-> !soft_reset_pull_reset)
    else $error("soft reset pulled reset despite option");

  a_ov_int: assert property (@(posedge clk_sys) disable iff (rst) // see R5
    (overvoltage_event && ms_val[10:9] == 2'h1) |=> (ov_int_event && !ov_reset_event && !ov_failsafe_event))
    else $error("overvoltage interrupt misrouted");

  a_ov_failsafe: assert property (@(posedge clk_sys) disable iff (rst) // see R5
    (overvoltage_event && ms_val[10:9] == 2'h3) |=> (ov_failsafe_event && !ov_int_event && !ov_reset_event))
    else $error("overvoltage fail-safe misrouted");

  a_ov_none: assert property (@(posedge clk_sys) disable iff (rst) // see R5
    (!overvoltage_event || ms_val[10:9] == 2'h0) |=> (!ov_int_event && !ov_reset_event && !ov_failsafe_event))
    else $error("overvoltage reaction without cause");

  a_swfo_gate: assert property (@(posedge clk_sys) disable iff (rst) // see R15
    (!failure_flag && !fail_pin_is_fail_output) |-> !fail_output)
    else $error("fail output on without pin mode");

  a_swfo_on: assert property (@(posedge clk_sys) disable iff (rst) // see R15
    (hw_val[5] && fail_pin_is_fail_output) |-> fail_output)
    else $error("software fail request ignored");

  a_ms_restart_keep: assert property (@(posedge clk_sys) disable iff (rst) // see R23
    restart_entry |=> (ms_val == ($past(ms_val) & `MSC_MS_KEEP)))
    else $error("mode register restart value wrong");

  a_hw_restart_keep: assert property (@(posedge clk_sys) disable iff (rst) // see R23
    restart_entry |=> (hw_val == ($past(hw_val) & `MSC_HW_RESTART_KEEP)))
    else $error("option register restart value wrong");

  a_ms_soft_zero: assert property (@(posedge clk_sys) disable iff (rst) // see R23
    (soft_reset_done && !restart_entry) |=> (ms_val == 16'h0000))
    else $error("mode register soft reset value wrong");

  a_hw_soft_keep: assert property (@(posedge clk_sys) disable iff (rst) // see R23
    (soft_reset_done && !restart_entry) |=> (hw_val == ($past(hw_val) & `MSC_HW_SOFT_KEEP)))
    else $error("option register soft reset value wrong");

  a_cfg_wdoff: assert property (@(posedge clk_sys) disable iff (rst) // see R20
    !wd_stop_off_bit_zero |-> !cfg.watchdog_stop_off)
    else $error("watchdog off without companion bit");

  a_wdoff_write: assert property (@(posedge clk_sys) disable iff (rst) // see R18
    (wr_hw && !restart_entry && !soft_reset_done && !stop_to_normal)
      |=> ((hw_val & 16'h0004) == ($past(req.wdata) & 16'h0004)))
    else $error("watchdog off bit not written");

  a_wdoff_hold: assert property (@(posedge clk_sys) disable iff (rst) // see R18
    (!wr_hw && !stop_to_normal && !restart_entry && !soft_reset_done)
      |=> ((hw_val & 16'h0004) == ($past(hw_val) & 16'h0004)))
    else $error("watchdog off bit changed on its own");

endmodule

// file: sim/msc_host.sv
// Host master model: issues single-word register reads and writes
// Assumes msc_regs takes a request on one edge and answers with rvalid one cycle later
`timescale 1ns/1ps
`include "msc_defs.svh"
module msc_host (
  // Clock
  input wire logic clk_sys,
  // Register access
  output msc_pkg::msc_req_s req,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  initial req = '0;

  // One access; raw skips the zeroing of reserved positions
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [15:0] d, input logic raw,
                      output logic [15:0] q);
    logic [15:0] m;
    m = (a == `MSC_ADDR_HW_OPTION) ? `MSC_HW_WMASK : `MSC_MS_WMASK;
    @(posedge clk_sys);
    #1;
    req = '{valid: 1'b1, write: wr, addr: a, wdata: raw ? d : (d & m)};
    @(posedge clk_sys);
    #1;
    req.valid = 1'b0;
    req.wdata = ~req.wdata;
    q = (rvalid === 1'b1) ? rdata : 16'hXXXX;
  endtask
endmodule

// file: sim/tb_msc_regs.sv
// Testbench for the mode/supply and hardware option register bank
// Assumes msc_host drives the register requests
`timescale 1ns/1ps
`include "msc_defs.svh"
module tb_msc_regs;
  logic clk_sys, rst, in_stop, in_normal, restart_entry, soft_reset_done, wd_stop_off_bit_zero;
  logic fail_pin_is_fail_output, failure_flag, overvoltage_event, rvalid, mode_req_pulse, soft_reset_req;
  logic soft_reset_pull_reset, ov_int_event, ov_reset_event, ov_failsafe_event, fail_output;
  logic [15:0] rdata, q;
  logic [31:0] reset_delay_cycles;
  msc_pkg::msc_req_s req;
  msc_pkg::msc_mode_e mode_request;
  msc_pkg::msc_cfg_s cfg;
  int err_count, n_compared, cycles;
  localparam logic [6:0] MS = `MSC_ADDR_MODE_SUPPLY;
  localparam logic [6:0] HW = `MSC_ADDR_HW_OPTION;

  msc_regs dut_u (.clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .in_stop(in_stop),
    .in_normal(in_normal), .restart_entry(restart_entry), .soft_reset_done(soft_reset_done),
    .wd_stop_off_bit_zero(wd_stop_off_bit_zero), .fail_pin_is_fail_output(fail_pin_is_fail_output),
    .failure_flag(failure_flag), .overvoltage_event(overvoltage_event), .mode_request(mode_request),
    .mode_req_pulse(mode_req_pulse), .soft_reset_req(soft_reset_req), .soft_reset_pull_reset(soft_reset_pull_reset),
    .ov_int_event(ov_int_event), .ov_reset_event(ov_reset_event), .ov_failsafe_event(ov_failsafe_event),
    .cfg(cfg), .reset_delay_cycles(reset_delay_cycles), .fail_output(fail_output));
  msc_host host_u (.clk_sys(clk_sys), .req(req), .rdata(rdata), .rvalid(rvalid));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("counts: %0d compared, %0d mismatches", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic raw = 1'b0);
    host_u.xfer(1'b1, a, d, raw, q);
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] e, input string m);
    host_u.xfer(1'b0, a, 16'h0000, 1'b0, q);
    chk(q, e, m);
  endtask

  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("mismatch at %0t: timeout", $time);
      test_done();
    end
  end

  initial begin
    rst = 1'b1;
    in_stop = 1'b0;
    in_normal = 1'b1;
    restart_entry = 1'b0;
    soft_reset_done = 1'b0;
    wd_stop_off_bit_zero = 1'b0;
    fail_pin_is_fail_output = 1'b0;
    failure_flag = 1'b0;
    overvoltage_event = 1'b0;
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    rd(MS, 16'h0000, "ms power-on");
    rd(HW, 16'h0000, "hw power-on");
    rd(7'h05, 16'h0000, "unmapped read");
    $display("test power-on done");
    // Reserved bits and field decode
    wr(MS, 16'h3FFF, 1'b1);
    rd(MS, 16'h06A3, "ms reserved");
    chk({cfg.hys_highest, cfg.peak_high, cfg.reset_thr}, 4'hF, "ms fields");
    wr(HW, 16'hFFFF, 1'b1);
    rd(HW, 16'h1E64, "hw reserved");
    chk({cfg.thermal_wait_ext, cfg.supply_ov_high, cfg.sample_hold_off}, 3'h7, "hw fields");
    chk({cfg.reset_delay_short, reset_delay_cycles}, {1'b1, 32'h0000C350}, "short delay");
    chk(cfg.watchdog_stop_off, 1'b0, "wd off needs bit zero");
    wd_stop_off_bit_zero = 1'b1;
    #1;
    chk(cfg.watchdog_stop_off, 1'b1, "wd off both bits");
    chk(fail_output, 1'b0, "fail needs pin mode");
    tick();
    fail_pin_is_fail_output = 1'b1;
    #1;
    chk(fail_output, 1'b1, "sw fail on");
    failure_flag = 1'b1;
    wr(HW, 16'h0000);
    chk({fail_output, reset_delay_cycles}, {1'b1, 32'h0003D090}, "failure holds output");
    tick();
    failure_flag = 1'b0;
    #1;
    chk(fail_output, 1'b0, "flag cleared");
    $display("test fields done");
    // Mode codes, soft reset pin option
    for (int i = 0; i < 4; i++) begin
      wr(MS, {i[1:0], 14'h0000});
      chk({mode_req_pulse, soft_reset_req, soft_reset_pull_reset}, {1'b1, i == 3, i == 3}, "mode write");
      if (i < 3) chk(mode_request, i[1:0], "mode code");
    end
    wr(HW, 16'h0040);
    wr(MS, 16'hC000);
    chk({cfg.soft_reset_keep_pin, soft_reset_req, soft_reset_pull_reset}, 3'h6, "soft reset keeps pin");
    wr(MS, 16'h8000);
    rd(MS, 16'h8000, "written mode readback");
    in_stop = 1'b1;
    in_normal = 1'b0;
    wr(MS, 16'h4000);
    chk(mode_request, msc_pkg::MSC_MODE_STOP, "no stop to sleep");
    wr(HW, 16'h0004);
    tick();
    in_stop = 1'b0;
    in_normal = 1'b1;
    tick();
    rd(HW, 16'h0000, "wd bit one cleared");
    $display("test modes done");
    // Overvoltage reaction codes
    for (int i = 0; i < 4; i++) begin
      wr(MS, {5'h00, i[1:0], 9'h000});
      overvoltage_event = 1'b1;
      tick();
      overvoltage_event = 1'b0;
      chk({ov_int_event, ov_reset_event, ov_failsafe_event}, {i == 1, i == 2, i == 3}, "ov reaction");
    end
    $display("test overvoltage done");
    // Restart and soft reset presets
    wr(MS, 16'h86A3);
    wr(HW, 16'h1E64);
    restart_entry = 1'b1;
    tick();
    restart_entry = 1'b0;
    rd(MS, 16'h00A3, "restart ms");
    rd(HW, 16'h1240, "restart hw");
    chk(fail_output, 1'b0, "restart fail off");
    soft_reset_done = 1'b1;
    tick();
    soft_reset_done = 1'b0;
    rd(MS, 16'h0000, "soft reset ms");
    rd(HW, 16'h0200, "soft reset hw");
    $display("test presets done");
    test_done();
  end
endmodule
